//--- core/fps_pkg.sv
// Package with timing constants and state types for the fault protection sequencer.
package fps_pkg;

	// Clock rate.
	localparam int CLK_HZ = 50000000;
	localparam int CLK_NS = 20;

	// Overload fault timer, in milliseconds and in cycles (longer than this trips).
	localparam int FAULT_TIME_MS = 100;
	localparam int FAULT_CYCLES = FAULT_TIME_MS * (CLK_HZ / 1000);

	// Turn-off blanking, in nanoseconds and in cycles (least time, rounded up).
	localparam int BLANK_TIME_NS = 1000;
	localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLK_NS - 1) / CLK_NS;

	// Minimum overvoltage pulse width, in nanoseconds and in cycles (least time, rounded up).
	localparam int OV_MIN_NS = 600;
	localparam int OV_MIN_CYCLES = (OV_MIN_NS + CLK_NS - 1) / CLK_NS;

	// Successive qualified events needed to latch off.
	localparam int LATCH_EVENTS = 4;

	// Synchroniser stages on the pin inputs, added to the turn-off blanking.
	localparam int SYNC_STAGES = 2;

	// Reset values.
	localparam logic RST_INHIBIT = 1'b1;
	localparam logic RST_SOFT_START = 1'b1;

	// Overload sequencer states.
	typedef enum logic [1:0] {
		FPS_ST_START,
		FPS_ST_RUN,
		FPS_ST_SHUTDOWN
	} fps_state_t;

endpackage : fps_pkg

//--- core/fps_ov_if.sv
// Interface carrying the overvoltage qualifier signals between the top and its filter.
`timescale 1ns/1ns
interface fps_ov_if;
	logic gate_fall;
	logic cycle_start;
	logic ov_level;
	logic event_valid;
	logic cycle_clean;

	modport top (output gate_fall, output cycle_start, output ov_level, input event_valid, input cycle_clean);
	modport filt (input gate_fall, input cycle_start, input ov_level, output event_valid, output cycle_clean);
endinterface : fps_ov_if

//--- core/fps_ov_filter.sv
// Overvoltage blanking and minimum-width qualifier.
`timescale 1ns/1ns
module fps_ov_filter
	import fps_pkg::*;
#(
	parameter int BLANK_CNT = BLANK_CYCLES,
	parameter int MIN_CNT = OV_MIN_CYCLES
)
(
	// Clock, reset and enable.
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Link to the top module.
	fps_ov_if.filt ov
);

	localparam int CW = 16;

	if (BLANK_CNT < 1 || MIN_CNT < 1 || BLANK_CNT >= 2 ** CW || MIN_CNT >= 2 ** CW)
	begin : g_bad_counts
		$error("fps_ov_filter: counts out of range");
	end

	logic [CW-1:0] blank_reg, blank_next;
	logic [CW-1:0] width_reg, width_next;
	logic hit_reg, hit_next;
	logic valid_reg, valid_next;
	logic clean_reg, clean_next;

	always_comb
	begin
		blank_next = blank_reg;
		width_next = width_reg;
		hit_next = hit_reg;
		valid_next = 1'b0;
		clean_next = 1'b0;
		if (ov.gate_fall)
		begin
			blank_next = CW'(BLANK_CNT);
			width_next = '0;
		end
		else if (blank_reg != '0)
		begin
			blank_next = blank_reg - 1'b1;
			width_next = '0;
		end
		else if (ov.ov_level)
		begin
			if (width_reg != CW'(MIN_CNT))
				width_next = width_reg + 1'b1;
			if (width_reg == CW'(MIN_CNT - 1) && !hit_reg)
			begin
				valid_next = 1'b1;
				hit_next = 1'b1;
			end
		end
		else
			width_next = '0;
		if (ov.cycle_start)
		begin
			clean_next = !hit_reg && !valid_next;
			hit_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			blank_reg <= '0;
			width_reg <= '0;
			hit_reg <= 1'b0;
			valid_reg <= 1'b0;
			clean_reg <= 1'b0;
		end
		else if (clk_en_i)
		begin
			blank_reg <= blank_next;
			width_reg <= width_next;
			hit_reg <= hit_next;
			valid_reg <= valid_next;
			clean_reg <= clean_next;
		end
	end

	assign ov.event_valid = valid_reg;
	assign ov.cycle_clean = clean_reg;

endmodule : fps_ov_filter

//--- core/fps_sequencer.sv
// Top of the fault protection sequencer: overload hiccup timer and latch-off path.
`timescale 1ns/1ns
// Operation
// - Overload flag held over 100 ms continuously stops drive pulses.
// - After shutdown, restart once supply start threshold is regained.
// - Persistent fault repeats hiccup; cleared fault resumes normal switching.
// - Every restart after a fault shutdown begins with soft-start.
// - Compensation ramp enabled only during drive on phase.
// - Latch-off detection uses the 3 V comparator output as overvoltage event.
// - Ignore comparator for 1 us after each drive turn-off edge.
// - Accept event only if comparator high at least 600 ns.
// - Latch off after 4 successive qualified events.
// - Latched off keeps switching disabled and supply clamped until power cycle.
// - Latch releases if hold current drops below 30 uA.
module fps_sequencer
	import fps_pkg::*;
#(
	parameter int FAULT_CNT = FAULT_CYCLES,
	parameter int EVENTS = LATCH_EVENTS
)
(
	// Clock, reset and enable.
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Asynchronous status inputs.
	input wire logic overload_flag_i,
	input wire logic power_limit_pin_cmp_i,
	input wire logic supply_start_threshold_i,
	input wire logic hold_current_ok_i,
	// Gate timing from the modulator.
	input wire logic gate_on_i,
	// Control outputs.
	output logic drive_inhibit_o,
	output logic soft_start_o,
	output logic ramp_enable_o,
	output logic latch_hold_element_o,
	output logic supply_clamp_o
);

	localparam int FW = $clog2(FAULT_CNT + 2);
	localparam int EW = $clog2(EVENTS + 1);

	if (FAULT_CNT < 1 || EVENTS < 1)
	begin : g_bad_counts
		$error("fps_sequencer: counts out of range");
	end

	// Two-stage synchronisers for the four asynchronous status inputs; gate_on_i is used unsynchronised.
	logic [3:0] sync1_reg, sync2_reg;
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else if (clk_en_i)
		begin
			sync1_reg <= {hold_current_ok_i, supply_start_threshold_i, power_limit_pin_cmp_i, overload_flag_i};
			sync2_reg <= sync1_reg;
		end
	end

	logic fault_s, ov_s, vcc_ok_s, hold_s;
	assign fault_s = sync2_reg[0];
	assign ov_s = sync2_reg[1];
	assign vcc_ok_s = sync2_reg[2];
	assign hold_s = sync2_reg[3];

	fps_ov_if ov_link ();

	// Blanking also covers the synchroniser delay on the comparator.
	fps_ov_filter #(
		.BLANK_CNT(BLANK_CYCLES + SYNC_STAGES),
		.MIN_CNT(OV_MIN_CYCLES)
	) u_filter (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.ov(ov_link.top)
	);

	// Counts up by one and holds at the limit.
	function automatic int sat_step(input int value, input int limit);
		if (value < limit)
			return value + 1;
		return value;
	endfunction : sat_step

	fps_state_t state_reg, state_next;
	logic [FW-1:0] ftimer_reg, ftimer_next;
	logic [EW-1:0] ev_reg, ev_next;
	logic latched_reg, latched_next;
	logic gate_d_reg, gate_d_next;
	logic inhibit_reg, inhibit_next;
	logic ss_reg, ss_next;
	logic ramp_reg, ramp_next;
	logic armed_reg, armed_next;
	logic latch_release;

	assign ov_link.gate_fall = gate_d_reg && !gate_on_i;
	assign ov_link.cycle_start = !gate_d_reg && gate_on_i;
	assign ov_link.ov_level = ov_s && !gate_on_i;

	assign latch_release = latched_reg && !hold_s;

	// Latch-off path: successive qualified events and the hold element.
	always_comb
	begin
		ev_next = ev_reg;
		latched_next = latched_reg;
		if (ov_link.event_valid)
			ev_next = EW'(sat_step(int'(ev_reg), EVENTS));
		else if (ov_link.cycle_clean)
			ev_next = '0;
		if (ev_reg == EW'(EVENTS))
			latched_next = 1'b1;
		if (latch_release)
		begin
			latched_next = 1'b0;
			ev_next = '0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ev_reg <= '0;
			latched_reg <= 1'b0;
		end
		else if (clk_en_i)
		begin
			ev_reg <= ev_next;
			latched_reg <= latched_next;
		end
	end

	// Overload hiccup sequencer.
	always_comb
	begin
		state_next = state_reg;
		ftimer_next = ftimer_reg;
		armed_next = armed_reg;
		gate_d_next = gate_on_i;
		ss_next = ss_reg;
		// Overload timer runs only while the flag stays high.
		if (fault_s && state_reg == FPS_ST_RUN)
			ftimer_next = FW'(sat_step(int'(ftimer_reg), FAULT_CNT + 1));
		else
			ftimer_next = '0;
		case (state_reg)
			FPS_ST_START:
			begin
				ss_next = 1'b1;
				if (vcc_ok_s)
					state_next = FPS_ST_RUN;
			end
			FPS_ST_RUN:
			begin
				if (ftimer_reg == FW'(FAULT_CNT) && fault_s)
				begin
					state_next = FPS_ST_SHUTDOWN;
					armed_next = 1'b0;
				end
				else if (ov_link.cycle_start)
					ss_next = 1'b0;
			end
			FPS_ST_SHUTDOWN:
			begin
				// Wait for supply to sag below the start threshold, then rise again.
				if (!vcc_ok_s)
					armed_next = 1'b1;
				else if (armed_reg)
				begin
					state_next = FPS_ST_RUN;
					ss_next = 1'b1;
				end
			end
			default:
				state_next = FPS_ST_START;
		endcase
		if (latch_release)
		begin
			state_next = FPS_ST_SHUTDOWN;
			armed_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_reg <= FPS_ST_START;
			ftimer_reg <= '0;
			armed_reg <= 1'b0;
			gate_d_reg <= 1'b0;
			ss_reg <= RST_SOFT_START;
		end
		else if (clk_en_i)
		begin
			state_reg <= state_next;
			ftimer_reg <= ftimer_next;
			armed_reg <= armed_next;
			gate_d_reg <= gate_d_next;
			ss_reg <= ss_next;
		end
	end

	// Drive controls, registered from the next state so that they move with it.
	always_comb
	begin
		inhibit_next = latched_next || state_next != FPS_ST_RUN;
		ramp_next = gate_on_i && !inhibit_next;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			inhibit_reg <= RST_INHIBIT;
			ramp_reg <= 1'b0;
		end
		else if (clk_en_i)
		begin
			inhibit_reg <= inhibit_next;
			ramp_reg <= ramp_next;
		end
	end

	assign drive_inhibit_o = inhibit_reg;
	assign soft_start_o = ss_reg;
	assign ramp_enable_o = ramp_reg;
	assign latch_hold_element_o = latched_reg;
	assign supply_clamp_o = latched_reg;

endmodule : fps_sequencer

//--- verif/fps_sequencer_props.sv
// Checker with concurrent assertions on the fault protection sequencer ports.
`timescale 1ns/1ns
module fps_sequencer_props
	import fps_pkg::*;
#(
	parameter int FAULT_CNT = FAULT_CYCLES,
	parameter int EVENTS = LATCH_EVENTS
)
(
	// Clock, reset and enable.
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Status and gate inputs.
	input wire logic overload_flag_i,
	input wire logic power_limit_pin_cmp_i,
	input wire logic supply_start_threshold_i,
	input wire logic hold_current_ok_i,
	input wire logic gate_on_i,
	// Control outputs.
	input wire logic drive_inhibit_o,
	input wire logic soft_start_o,
	input wire logic ramp_enable_o,
	input wire logic latch_hold_element_o,
	input wire logic supply_clamp_o
);
	int unsigned ovl_cnt_reg;
	int unsigned ovl_cnt_next;

	// Counts consecutive cycles with the overload flag high.
	always_comb
	begin
		ovl_cnt_next = overload_flag_i ? ovl_cnt_reg + 1 : 0;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ovl_cnt_reg <= 0;
		else if (clk_en_i)
			ovl_cnt_reg <= ovl_cnt_next;
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	AST_RAMP_ON: assert property (ramp_enable_o |-> $past(gate_on_i))
		else $error("ramp on outside drive on phase");
	AST_RAMP_INH: assert property (ramp_enable_o |-> !drive_inhibit_o)
		else $error("ramp on while inhibited");
	AST_LATCH_INH: assert property (latch_hold_element_o |-> drive_inhibit_o)
		else $error("latched but drive not inhibited");
	AST_CLAMP: assert property (supply_clamp_o == latch_hold_element_o)
		else $error("clamp differs from latch");
	AST_HOLD_REL: assert property ((!hold_current_ok_i) [*4] |-> !latch_hold_element_o)
		else $error("latch kept without hold current");
	AST_FAULT_MIN: assert property ($rose(drive_inhibit_o) && !latch_hold_element_o |-> ovl_cnt_reg > FAULT_CNT)
		else $error("drive stopped before overload time");
	AST_FAULT_TRIP: assert property (ovl_cnt_reg == FAULT_CNT + 8 |-> drive_inhibit_o)
		else $error("drive not stopped after overload time");
	AST_SOFT: assert property ($fell(drive_inhibit_o) |-> soft_start_o)
		else $error("restart without soft start");
	AST_START: assert property ($fell(drive_inhibit_o) |-> $past(supply_start_threshold_i, 3))
		else $error("restart without supply threshold");
	AST_LATCH_KEEP: assert property ($fell(latch_hold_element_o) |-> !$past(hold_current_ok_i, 3))
		else $error("latch released while hold current present");
endmodule : fps_sequencer_props

bind fps_sequencer fps_sequencer_props #(.FAULT_CNT(FAULT_CNT), .EVENTS(EVENTS)) i_props (
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
	.overload_flag_i(overload_flag_i), .power_limit_pin_cmp_i(power_limit_pin_cmp_i),
	.supply_start_threshold_i(supply_start_threshold_i), .hold_current_ok_i(hold_current_ok_i),
	.gate_on_i(gate_on_i), .drive_inhibit_o(drive_inhibit_o), .soft_start_o(soft_start_o),
	.ramp_enable_o(ramp_enable_o), .latch_hold_element_o(latch_hold_element_o),
	.supply_clamp_o(supply_clamp_o));

//--- verif/fps_sequencer_test.sv
// Self-checking bench for the fault protection sequencer.
`timescale 1ns/1ns
module fps_sequencer_test;
	import fps_pkg::*;
	typedef struct {logic [4:0] m; int s; int w; logic e;} fps_row_t;
	logic clk = 0, rst_n = 0, ovl = 0, cmp = 0, sup = 0, hold = 1, gate = 0, en = 1;
	logic inh, ss, ramp, lat, clamp;
	int n_errors = 0, compares = 0;
	fps_row_t rows [5] = '{'{5'h0f, 60, 40, 1}, '{5'h07, 60, 40, 0}, '{5'h0f, 60, 20, 0},
		'{5'h1b, 60, 40, 0}, '{5'h0f, 0, 45, 0}};

	always #10 clk = ~clk;

	fps_sequencer #(.FAULT_CNT(200)) i_dut (.sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(en),
		.overload_flag_i(ovl), .power_limit_pin_cmp_i(cmp), .supply_start_threshold_i(sup),
		.hold_current_ok_i(hold), .gate_on_i(gate), .drive_inhibit_o(inh), .soft_start_o(ss),
		.ramp_enable_o(ramp), .latch_hold_element_o(lat), .supply_clamp_o(clamp));

	task automatic chk(string n, logic seen, logic exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %b seen %b", n, exp, seen);
		end
	endtask : chk

	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// One switching cycle, with the comparator high from s for w cycles of the off phase.
	task automatic sw(logic ev, int s, int w);
		gate = 1;
		cyc(20);
		gate = 0;
		for (int i = 0; i < 150; i++)
		begin
			cmp = ev && i >= s && i < s + w;
			cyc(1);
		end
	endtask : sw

	task automatic boot();
		rst_n = 0;
		sup = 0;
		cyc(16);
		chk("inhibit", inh, RST_INHIBIT);
		chk("soft", ss, RST_SOFT_START);
		chk("latch", lat, 1'b0);
		rst_n = 1;
		sup = 1;
		cyc(6);
		chk("inhibit", inh, 1'b0);
	endtask : boot

	task automatic restart();
		sup = 0;
		cyc(5);
		sup = 1;
		cyc(6);
	endtask : restart

	task automatic report_and_stop();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	initial
	begin
		foreach (rows[r])
		begin
			boot();
			for (int c = 0; c < 5; c++)
				sw(rows[r].m[c], rows[r].s, rows[r].w);
			gate = 1;
			cyc(3);
			chk("latch", lat, rows[r].e);
			chk("clamp", clamp, rows[r].e);
			$display("row %0d done", r);
		end
		boot();
		repeat (4) sw(1'b1, 60, 40);
		restart();
		chk("latch", lat, 1'b1);
		hold = 0;
		cyc(6);
		chk("latch", lat, 1'b0);
		chk("inhibit", inh, 1'b1);
		hold = 1;
		$display("latch release done");
		boot();
		en = 0;
		gate = 1;
		cyc(3);
		chk("ramp", ramp, 1'b0);
		chk("soft", ss, 1'b1);
		en = 1;
		cyc(3);
		chk("ramp", ramp, 1'b1);
		gate = 0;
		cyc(3);
		chk("ramp", ramp, 1'b0);
		chk("soft", ss, 1'b0);
		ovl = 1;
		cyc(150);
		ovl = 0;
		cyc(5);
		chk("inhibit", inh, 1'b0);
		ovl = 1;
		cyc(195);
		chk("inhibit", inh, 1'b0);
		cyc(15);
		chk("inhibit", inh, 1'b1);
		restart();
		chk("inhibit", inh, 1'b0);
		chk("soft", ss, 1'b1);
		cyc(230);
		chk("inhibit", inh, 1'b1);
		ovl = 0;
		restart();
		cyc(300);
		chk("inhibit", inh, 1'b0);
		$display("overload done");
		report_and_stop();
	end

	initial
	begin
		cyc(20000);
		n_errors++;
		report_and_stop();
	end
endmodule : fps_sequencer_test
